// [core/nvsc_delay.sv]
// Power-up recovery timer for the SRAM host controller.
// Assumes supply_ok_i is already synchronous; it counts the recovery delay after each rise.
`timescale 1ns/10ps
module nvsc_delay #(
    parameter int unsigned RECOVERY_CYC = nvsc_pkg::RECOVERY_CYC_DEF
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Supply state and the settled result.
    input wire logic supply_ok_i,
    output logic ready_o
);
    logic [nvsc_pkg::REC_W-1:0] cnt_q, cnt_d;
    logic ready_q, ready_d;

    // Restart the count whenever the supply is not good; ready only after a full delay.
    always_comb begin
        cnt_d = cnt_q;
        ready_d = ready_q;
        if (!supply_ok_i) begin
            cnt_d = '0;
            ready_d = 1'b0;
        end else if (!ready_q) begin
            if (cnt_q >= nvsc_pkg::REC_W'(RECOVERY_CYC - 1)) begin
                ready_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // Register the timer state.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end

    assign ready_o = ready_q;
endmodule

// [core/nvsc_host.sv]
// Host controller that drives a battery-backed 8K x 8 asynchronous SRAM through its pins.
// Assumes pin inputs are synchronous to clk_i and a supply-good level from a board monitor.
`timescale 1ns/10ps
module nvsc_host #(
    parameter int unsigned RECOVERY_CYC = nvsc_pkg::RECOVERY_CYC_DEF
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Board supply monitor: high while the supply is above the upper threshold.
    input wire logic supply_ok_i,
    // User request port.
    input wire logic req_valid_i,
    input wire nvsc_pkg::nvsc_req_t req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [nvsc_pkg::DATA_W-1:0] rsp_data_o,
    output logic power_lost_o,
    // Memory pins.
    output logic mem_select_n_o,
    output logic mem_strobe_n_o,
    output logic mem_gate_n_o,
    output logic [nvsc_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [nvsc_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    input wire logic [nvsc_pkg::DATA_W-1:0] mem_data_i
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WPULSE,
        ST_WHOLD,
        ST_READ,
        ST_RHOLD
    } nvsc_state_t;

    nvsc_state_t state_q, state_d;
    nvsc_pkg::nvsc_pins_t pins_q, pins_d;
    nvsc_pkg::nvsc_req_t cur_q, cur_d;
    logic [nvsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic ready_q, ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [nvsc_pkg::DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic lost_q, lost_d;
    logic settled;

    // Recovery timer: goes high only after the supply has stayed good for the delay.
    nvsc_delay #(
        .RECOVERY_CYC(RECOVERY_CYC)
    ) u_delay (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .supply_ok_i(supply_ok_i),
        .ready_o(settled)
    );

    // Sequence one access at a time and drive the pins from registers.
    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        cur_d = cur_q;
        cnt_d = cnt_q;
        ready_d = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        lost_d = lost_q;
        if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
        unique case (state_q)
            ST_IDLE: begin
                pins_d.select_n = 1'b1;
                pins_d.strobe_n = 1'b1;
                pins_d.gate_n = 1'b1;
                pins_d.data_oe = 1'b0;
                ready_d = settled;
                if (ready_q && req_valid_i && settled && supply_ok_i) begin
                    cur_d = req_i;
                    lost_d = 1'b0;
                    ready_d = 1'b0;
                    pins_d.addr = req_i.addr;
                    if (req_i.write) begin
                        pins_d.data = req_i.wdata;
                        pins_d.data_oe = 1'b1;
                        pins_d.gate_n = 1'b1;
                        state_d = ST_SETUP;
                        cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::SETUP_CYC);
                    end else begin
                        pins_d.select_n = 1'b0;
                        pins_d.gate_n = 1'b0;
                        state_d = ST_READ;
                        cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::READ_ACCESS_CYC);
                    end
                end
            end
            ST_SETUP: begin
                // Select and strobe fall together, one cycle after the address, and start the write.
                pins_d.select_n = 1'b0;
                if (cnt_q <= 1) begin
                    pins_d.strobe_n = 1'b0;
                    state_d = ST_WPULSE;
                    cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::WRITE_PULSE_CYC);
                end
            end
            ST_WPULSE: begin
                if (cnt_q <= 1) begin
                    pins_d.strobe_n = 1'b1;
                    state_d = ST_WHOLD;
                    cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::RELEASE_HOLD_CYC);
                end
            end
            ST_WHOLD: begin
                // Address and data stay put through the release hold.
                pins_d.select_n = 1'b1;
                if (cnt_q <= 1) begin
                    pins_d.data_oe = 1'b0;
                    state_d = ST_IDLE;
                    rsp_valid_d = 1'b1;
                end
            end
            ST_READ: begin
                if (cnt_q <= 1) begin
                    rsp_data_d = mem_data_i;
                    pins_d.select_n = 1'b1;
                    pins_d.gate_n = 1'b1;
                    state_d = ST_RHOLD;
                    cnt_d = nvsc_pkg::CNT_W'(nvsc_pkg::GATE_FLOAT_CYC);
                end
            end
            ST_RHOLD: begin
                // Let the memory float the bus before any write may drive it.
                if (cnt_q <= 1) begin
                    state_d = ST_IDLE;
                    rsp_valid_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Supply failure aborts the access at once, ahead of the timer's own flag.
        if ((!settled || !supply_ok_i) && state_q != ST_IDLE) begin
            lost_d = (state_q == ST_WPULSE) || (state_q == ST_SETUP);
            pins_d.select_n = 1'b1;
            pins_d.strobe_n = 1'b1;
            pins_d.gate_n = 1'b1;
            pins_d.data_oe = 1'b0;
            state_d = ST_IDLE;
            ready_d = 1'b0;
            rsp_valid_d = 1'b1;
        end
    end

    // Register controller state; strobes idle high from reset.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            pins_q <= '{select_n: 1'b1, strobe_n: 1'b1, gate_n: 1'b1, addr: '0, data: '0, data_oe: 1'b0};
            cur_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
            lost_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pins_q <= pins_d;
            cur_q <= cur_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            lost_q <= lost_d;
        end
    end

    // Outputs straight from registers.
    assign req_ready_o = ready_q;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;
    assign power_lost_o = lost_q;
    assign mem_select_n_o = pins_q.select_n;
    assign mem_strobe_n_o = pins_q.strobe_n;
    assign mem_gate_n_o = pins_q.gate_n;
    assign mem_addr_o = pins_q.addr;
    assign mem_data_o = pins_q.data;
    assign mem_data_oe_o = pins_q.data_oe;
endmodule

// [core/nvsc_pkg.sv]
// Package for the battery-backed SRAM host controller: timing counts and carrier structs.
// Assumes a 250 MHz system clock; all counts are derived from nanosecond or microsecond figures.
package nvsc_pkg;
    // Clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Array geometry.
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned DATA_W = 8;
    // Write strobe pulse width, least, in ns.
    localparam int unsigned WRITE_PULSE_NS = 80;
    // Address hold after the terminating edge, least, in ns.
    localparam int unsigned RELEASE_HOLD_NS = 10;
    // Strobe to data float delay, longest, in ns.
    localparam int unsigned STROBE_TO_FLOAT_NS = 50;
    // Address setup ahead of the strobe, in ns (kept at one cycle minimum).
    localparam int unsigned ADDR_SETUP_NS = 4;
    // Read access time from select, longest, in ns.
    localparam int unsigned READ_ACCESS_NS = 100;
    // Data float after the output gate rises, longest, in ns.
    localparam int unsigned GATE_FLOAT_NS = 40;
    // Recovery delay after power returns, least, in microseconds.
    localparam int unsigned RECOVERY_DELAY_US = 2000;
    // Derived counts round up (read access adds one cycle), except strobe to float and the recovery count, which round down; none below one.
    localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RELEASE_HOLD_CYC = (RELEASE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int unsigned GATE_FLOAT_CYC = (GATE_FLOAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STROBE_TO_FLOAT_CYC = (STROBE_TO_FLOAT_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned RECOVERY_CYC_DEF = (RECOVERY_DELAY_US * 1000000) / CLK_PERIOD_PS;
    // Widths of the phase counter and the recovery counter.
    localparam int unsigned CNT_W = 8;
    localparam int unsigned REC_W = 24;

    // Request from the user side.
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvsc_req_t;

    // Pin group driven toward the memory; active-low strobes.
    typedef struct packed {
        logic select_n;
        logic strobe_n;
        logic gate_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic data_oe;
    } nvsc_pins_t;
endpackage

// [sim/nvsc_host_assertions.sv]
// Pin protocol checker for the SRAM host controller, bound into nvsc_host.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/10ps
module nvsc_host_chk #(
    parameter int unsigned RECOVERY_CYC = 20
) (
    // Clock, reset, supply monitor and power-loss flag.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_ok_i,
    input wire logic power_lost_o,
    // Memory pins.
    input wire logic mem_select_n_o,
    input wire logic mem_strobe_n_o,
    input wire logic mem_gate_n_o,
    input wire logic [nvsc_pkg::ADDR_W-1:0] mem_addr_o,
    input wire logic mem_data_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    int unsigned ok_q, ok_d;
    // Counts settled supply cycles, saturating at the recovery figure.
    always_comb begin
        ok_d = !supply_ok_i ? 0 : (ok_q < RECOVERY_CYC ? ok_q + 1 : ok_q);
    end
    // Registers the settled supply count.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ok_q <= 0;
        end else begin
            ok_q <= ok_d;
        end
    end
    a_gate_in_write: assert property (!mem_strobe_n_o |-> mem_gate_n_o)
        else $error("output gate low while strobe low");
    a_drive_no_gate: assert property (mem_data_oe_o |-> mem_gate_n_o)
        else $error("host drives data with gate low");
    a_addr_in_write: assert property (!mem_strobe_n_o |-> $stable(mem_addr_o))
        else $error("address moved during write");
    a_release_hold: assert property ($rose(mem_strobe_n_o) && supply_ok_i |-> $stable(mem_addr_o)[*3] ##1 mem_select_n_o)
        else $error("address or select not held after write");
    a_select_on_fail: assert property (!supply_ok_i |=> mem_select_n_o)
        else $error("select low with supply unsettled");
    a_wait_recovery: assert property (ok_q < RECOVERY_CYC |-> mem_select_n_o)
        else $error("access before recovery delay");
    cover property ($rose(mem_strobe_n_o));
    cover property ($fell(mem_gate_n_o));
    cover property ($rose(power_lost_o));
endmodule
bind nvsc_host nvsc_host_chk #(.RECOVERY_CYC(RECOVERY_CYC)) nvsc_host_chk_i (.clk_i, .rst_n_i, .supply_ok_i,
    .power_lost_o, .mem_select_n_o, .mem_strobe_n_o, .mem_gate_n_o, .mem_addr_o, .mem_data_oe_o);

// [sim/nvsc_host_tb_top.sv]
// Self-checking bench: host controller against the memory model.
// Assumes a 250 MHz clock and a shortened recovery count.
`timescale 1ns/10ps
module nvsc_host_tb_top;
    localparam int unsigned REC = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic supply_ok_i = 1'b0;
    logic req_valid_i = 1'b0;
    nvsc_pkg::nvsc_req_t req_i = '0;
    logic req_ready_o, rsp_valid_o, power_lost_o, sel_n, stb_n, gate_n, h_oe, m_oe;
    logic [7:0] rsp_data_o, h_dq, m_dq, rd;
    logic [7:0] last_q = 8'h00;
    logic [12:0] addr;
    int errors = 0;
    int n_compared = 0;
    // Released lines show a pattern that flips every cycle.
    wire [7:0] dq = h_oe ? h_dq : (m_oe ? m_dq : ~last_q);
    nvsc_host #(.RECOVERY_CYC(REC)) nvsc_host_i (.clk_i, .rst_n_i, .supply_ok_i, .req_valid_i, .req_i,
        .req_ready_o, .rsp_valid_o, .rsp_data_o, .power_lost_o, .mem_select_n_o(sel_n), .mem_strobe_n_o(stb_n),
        .mem_gate_n_o(gate_n), .mem_addr_o(addr), .mem_data_o(h_dq), .mem_data_oe_o(h_oe), .mem_data_i(dq));
    nvsc_sram_model #(.REC_NS(REC * 4)) nvsc_sram_model_i (.select_n_i(sel_n), .strobe_n_i(stb_n),
        .gate_n_i(gate_n), .supply_ok_i, .addr_i(addr), .data_i(dq), .data_o(m_dq), .data_oe_o(m_oe));
    // Clock generation and the idle-line pattern.
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) last_q <= dq;
    // Compares one value and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits for ready, then presents one request for exactly one take.
    task automatic issue(input logic wr, input logic [12:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 200) errors++;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{wr, a, d};
        @(posedge clk_i);
        req_valid_i <= 1'b0;
    endtask
    // Waits for the completion pulse and keeps its data.
    task automatic finish;
        int n;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 100) errors++;
        rd = rsp_data_o;
    endtask
    task automatic op(input logic wr, input logic [12:0] a, input logic [7:0] d);
        issue(wr, a, d);
        finish;
    endtask
    // Nothing is accessed until the recovery delay has passed.
    task automatic t_power_up;
        repeat (REC / 2) @(negedge clk_i);
        chk(req_ready_o, 1'b0);
        chk(sel_n, 1'b1);
        op(1'b1, 13'h0000, 8'h5a);
        $display("test power_up done");
    endtask
    // Back-to-back writes at the address extremes, an overwrite, then read-back.
    task automatic t_write_read;
        logic [12:0] a [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
        logic [7:0] d [4] = '{8'ha5, 8'h3c, 8'hff, 8'h00};
        for (int i = 0; i < 4; i++) op(1'b1, a[i], d[i]);
        op(1'b1, 13'h1fff, 8'h81);
        d[1] = 8'h81;
        for (int i = 0; i < 4; i++) begin
            op(1'b0, a[i], 8'h00);
            chk(rd, d[i]);
        end
        $display("test write_read done");
    endtask
    // Supply fails mid-write; neighbours survive and access waits for recovery.
    task automatic t_power_fail;
        int n;
        n = 0;
        issue(1'b1, 13'h0aab, 8'h77);
        while (stb_n !== 1'b0 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 20) errors++;
        @(posedge clk_i);
        supply_ok_i <= 1'b0;
        finish;
        @(negedge clk_i);
        chk(power_lost_o, 1'b1);
        chk(sel_n, 1'b1);
        repeat (10) @(posedge clk_i);
        supply_ok_i <= 1'b1;
        repeat (REC / 2) @(negedge clk_i);
        chk(req_ready_o, 1'b0);
        op(1'b0, 13'h0aaa, 8'h00);
        chk(rd, 8'hff);
        chk(power_lost_o, 1'b0);
        op(1'b0, 13'h1555, 8'h00);
        chk(rd, 8'h00);
        $display("test power_fail done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence after four reset cycles.
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        supply_ok_i <= 1'b1;
        t_power_up;
        t_write_read;
        t_power_fail;
        test_done;
    end
    // Watchdog well beyond the expected few microseconds.
    initial begin
        #100000;
        errors++;
        test_done;
    end
endmodule

// [sim/nvsc_sram_model.sv]
// Behavioural battery-backed 8K x 8 static memory facing the host.
// Assumes the bench resolves the shared data lines from both enables.
`timescale 1ns/10ps
module nvsc_sram_model #(
    parameter int ACC_NS = 96,
    parameter int REC_NS = 80
) (
    // Active-low controls and supply state.
    input wire logic select_n_i,
    input wire logic strobe_n_i,
    input wire logic gate_n_i,
    input wire logic supply_ok_i,
    // Address and data lines.
    input wire logic [12:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o
);
    logic [7:0] mem [0:8191];
    logic blocked = 1'b1;
    logic wr;
    // A write lasts from the later falling strobe to the first rising one.
    assign wr = !select_n_i && !strobe_n_i && !blocked;
    // Stores at the end of the write; a power loss spoils only that byte.
    always @(negedge wr) begin
        mem[addr_i] = supply_ok_i ? data_i : ~data_i;
    end
    // Array content survives on the battery; protection lifts after recovery.
    always @(supply_ok_i) begin
        blocked = 1'b1;
        if (supply_ok_i) blocked <= #(REC_NS) 1'b0;
    end
    // Drives only for a read with the gate low, so a write leaves outputs floating.
    assign data_oe_o = !select_n_i && strobe_n_i && !gate_n_i && !blocked;
    assign #(ACC_NS) data_o = mem[addr_i];
endmodule
